//--- design/fspc_pkg.sv
package fspc_pkg;
  // ----
  // timing
  // ----
  localparam int CLK_NS = 40;
  localparam int PROG_NS = 2200000;
  localparam int PROG_CYC = PROG_NS / CLK_NS;
  localparam int UNL_NS = 40000;
  localparam int UNL_CYC = UNL_NS / CLK_NS;
  localparam int INSTR_CLKS = 4;
  localparam int RD_INSTR = 3;
  localparam int RD_CYC = RD_INSTR * INSTR_CLKS;
  localparam int TW = 16;
  // ----
  // array geometry
  // ----
  localparam int AW = 12;
  localparam int DW = 16;
  localparam logic [8:0] BLK_WORDS = 9'h100;
  localparam logic [8:0] UNIT_WORDS = 9'h004;
  // ----
  // device register offsets and control bits
  // ----
  localparam logic [7:0] A_FC0 = 8'h5a;
  localparam logic [7:0] A_ADDR_LOW_REG = 8'h5c;
  localparam logic [7:0] A_ADDR_HIGH_REG = 8'h5d;
  localparam logic [7:0] A_WORD0_LOW = 8'h5e;
  localparam logic [7:0] A_WORD3_HIGH = 8'h65;
  localparam int B_START = 7;
  localparam int B_MODE = 4;
  localparam int B_EN = 3;
  localparam int B_GO = 2;
  localparam int B_PERM = 1;
  localparam int B_RGO = 0;
  localparam logic [2:0] M_WRITE = 3'h0;
  localparam logic [2:0] M_ERASE = 3'h1;
  localparam logic [2:0] M_READ = 3'h3;
  localparam logic [2:0] M_UNLOCK = 3'h6;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // key bytes for data bytes 7 down to 2
  localparam logic [47:0] KEY = 48'h40c3090d0400;
  // ----
  // control words the host writes and status bits it polls
  // ----
  localparam logic [7:0] FC_UNL = 8'h60;
  localparam logic [7:0] FC_UNLGO = 8'he0;
  localparam logic [7:0] FC_ER = 8'h18;
  localparam logic [7:0] FC_ERGO = 8'h1c;
  localparam logic [7:0] FC_WR = 8'h08;
  localparam logic [7:0] FC_WRGO = 8'h0c;
  localparam logic [7:0] FC_RD = 8'h3a;
  localparam logic [7:0] FC_RDGO = 8'h3b;
  localparam logic [7:0] FC_LOCK = 8'h00;
  localparam logic [7:0] PM_START = 8'h80;
  localparam logic [7:0] PM_GO = 8'h04;
  localparam logic [7:0] PM_RGO = 8'h01;
  // ----
  // host software port
  // ----
  localparam logic [3:0] H_CMD = 4'h0;
  localparam logic [3:0] H_ADRL = 4'h1;
  localparam logic [3:0] H_ADRH = 4'h2;
  localparam logic [2:0] C_UNLOCK = 3'h0;
  localparam logic [2:0] C_ERASE = 3'h1;
  localparam logic [2:0] C_WRITE = 3'h2;
  localparam logic [2:0] C_READ = 3'h3;
  localparam logic [2:0] C_LOCK = 3'h4;
  typedef enum logic [1:0] {K_WR, K_POLL, K_CAP, K_END} fspc_kind_t;
  typedef struct packed {
    fspc_kind_t k;
    logic [7:0] a;
    logic [7:0] d;
  } fspc_step_t;
endpackage

//--- design/fspc_if.sv
`timescale 1ns/1ps
interface fspc_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic stall;
  modport dev(input addr, input wdata, input wr, input rd, output rdata, output stall);
  modport cpu(output addr, output wdata, output wr, output rd, input rdata, input stall);
endinterface

//--- design/fspc_timer.sv
`timescale 1ns/1ps
module fspc_timer (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_load,
  input wire logic [15:0] i_cnt,
  // status
  output logic o_done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic run;
  } fspc_tmr_t;

  fspc_tmr_t r_r;
  fspc_tmr_t r_nxt;

  assign o_done = r_r.run && (r_r.cnt == 16'h0001);

  always_comb begin
    r_nxt = r_r;
    if (i_load) begin
      r_nxt.cnt = i_cnt;
      r_nxt.run = 1'b1;
    end else if (r_r.run) begin
      r_nxt.cnt = r_r.cnt - 16'h0001;
      r_nxt.run = !o_done;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
endmodule

//--- design/fspc_host.sv
`timescale 1ns/1ps
module fspc_host (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // software port
  input wire logic [3:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  output logic O_BUSY,
  // device side
  fspc_if.cpu bus
);
  typedef enum logic [1:0] {H_IDLE, H_STEP, H_STB, H_DAT} fspc_hst_t;
  typedef struct packed {
    fspc_hst_t st;
    logic [2:0] cmd;
    logic [3:0] step;
    logic [11:0] adr;
    logic [7:0][7:0] dat;
    logic [7:0] oa;
    logic [7:0] owd;
    logic owr;
    logic ord;
    logic [7:0] srd;
  } fspc_host_t;

  fspc_host_t r_r;
  fspc_host_t r_nxt;
  fspc_pkg::fspc_step_t t;

  // ----
  // command sequences
  // ----
  function automatic fspc_pkg::fspc_step_t step_f(input logic [2:0] c, input logic [3:0] s,
                                        input logic [11:0] ad, input logic [7:0][7:0] dt);
    fspc_pkg::fspc_step_t v;
    int i;
    v = '{fspc_pkg::K_END, 8'h00, 8'h00};
    i = int'(s);
    unique case (c)
      fspc_pkg::C_UNLOCK: begin
        if (s == 4'h0) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_UNL};
        else if (s == 4'h1) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_UNLGO};
        else if (s < 4'h8) v = '{fspc_pkg::K_WR, 8'(fspc_pkg::A_WORD0_LOW + 8'(s)), fspc_pkg::KEY[8*(i-2) +: 8]};
        else if (s == 4'h8) v = '{fspc_pkg::K_POLL, fspc_pkg::A_FC0, fspc_pkg::PM_START};
      end
      fspc_pkg::C_ERASE: begin
        if (s == 4'h0) v = '{fspc_pkg::K_WR, fspc_pkg::A_ADDR_LOW_REG, ad[7:0]};
        else if (s == 4'h1) v = '{fspc_pkg::K_WR, fspc_pkg::A_ADDR_HIGH_REG, {4'h0, ad[11:8]}};
        else if (s == 4'h2) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_ER};
        else if (s == 4'h3) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_ERGO};
        else if (s == 4'h4) v = '{fspc_pkg::K_POLL, fspc_pkg::A_FC0, fspc_pkg::PM_GO};
      end
      fspc_pkg::C_WRITE: begin
        if (s == 4'h0) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_WR};
        else if (s == 4'h1) v = '{fspc_pkg::K_WR, fspc_pkg::A_ADDR_LOW_REG, ad[7:0]};
        else if (s == 4'h2) v = '{fspc_pkg::K_WR, fspc_pkg::A_ADDR_HIGH_REG, {4'h0, ad[11:8]}};
        else if (s < 4'hb) v = '{fspc_pkg::K_WR, 8'(fspc_pkg::A_WORD0_LOW + 8'(s - 4'h3)), dt[i-3]};
        else if (s == 4'hb) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_WRGO};
        else if (s == 4'hc) v = '{fspc_pkg::K_POLL, fspc_pkg::A_FC0, fspc_pkg::PM_GO};
      end
      fspc_pkg::C_READ: begin
        if (s == 4'h0) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_RD};
        else if (s == 4'h1) v = '{fspc_pkg::K_WR, fspc_pkg::A_ADDR_LOW_REG, ad[7:0]};
        else if (s == 4'h2) v = '{fspc_pkg::K_WR, fspc_pkg::A_ADDR_HIGH_REG, {4'h0, ad[11:8]}};
        else if (s == 4'h3) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_RDGO};
        else if (s == 4'h4) v = '{fspc_pkg::K_POLL, fspc_pkg::A_FC0, fspc_pkg::PM_RGO};
        else if (s == 4'h5) v = '{fspc_pkg::K_CAP, fspc_pkg::A_WORD0_LOW, 8'h00};
        else if (s == 4'h6) v = '{fspc_pkg::K_CAP, 8'(fspc_pkg::A_WORD0_LOW + 8'h01), 8'h01};
      end
      fspc_pkg::C_LOCK: begin
        if (s == 4'h0) v = '{fspc_pkg::K_WR, fspc_pkg::A_FC0, fspc_pkg::FC_LOCK};
      end
      default: begin
      end
    endcase
    return v;
  endfunction

  assign t = step_f(r_r.cmd, r_r.step, r_r.adr, r_r.dat);
  assign bus.addr = r_r.oa;
  assign bus.wdata = r_r.owd;
  assign bus.wr = r_r.owr;
  assign bus.rd = r_r.ord;
  assign O_RDATA = r_r.srd;
  assign O_BUSY = (r_r.st != H_IDLE);

  // ----
  // sequencer
  // ----
  always_comb begin
    r_nxt = r_r;
    r_nxt.srd = 8'h00;
    if (I_RD) begin
      if (I_ADDR == fspc_pkg::H_CMD) r_nxt.srd = {7'h00, O_BUSY};
      else if (I_ADDR == fspc_pkg::H_ADRL) r_nxt.srd = r_r.adr[7:0];
      else if (I_ADDR == fspc_pkg::H_ADRH) r_nxt.srd = {4'h0, r_r.adr[11:8]};
      else if (I_ADDR[3]) r_nxt.srd = r_r.dat[I_ADDR[2:0]];
    end
    unique case (r_r.st)
      H_IDLE: begin
        if (I_WR) begin
          if (I_ADDR == fspc_pkg::H_CMD) begin
            r_nxt.cmd = I_WDATA[2:0];
            r_nxt.step = 4'h0;
            r_nxt.st = H_STEP;
          end else if (I_ADDR == fspc_pkg::H_ADRL) r_nxt.adr[7:0] = I_WDATA;
          else if (I_ADDR == fspc_pkg::H_ADRH) r_nxt.adr[11:8] = I_WDATA[3:0];
          else if (I_ADDR[3]) r_nxt.dat[I_ADDR[2:0]] = I_WDATA;
        end
      end
      H_STEP: begin
        if (!bus.stall) begin
          if (t.k == fspc_pkg::K_END) begin
            r_nxt.st = H_IDLE;
          end else begin
            r_nxt.oa = t.a;
            r_nxt.owd = (t.k == fspc_pkg::K_WR) ? t.d : 8'h00;
            r_nxt.owr = (t.k == fspc_pkg::K_WR);
            r_nxt.ord = (t.k != fspc_pkg::K_WR);
            r_nxt.st = H_STB;
          end
        end
      end
      H_STB: begin
        r_nxt.owr = 1'b0;
        r_nxt.ord = 1'b0;
        if (t.k == fspc_pkg::K_WR) begin
          r_nxt.step = r_r.step + 4'h1;
          r_nxt.st = H_STEP;
        end else begin
          r_nxt.st = H_DAT;
        end
      end
      H_DAT: begin
        r_nxt.st = H_STEP;
        if (t.k == fspc_pkg::K_CAP) r_nxt.dat[t.d[2:0]] = bus.rdata;
        if (t.k == fspc_pkg::K_CAP || (bus.rdata & t.d) == 8'h00) r_nxt.step = r_r.step + 4'h1;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end
endmodule

//--- design/fspc_dev.sv
`timescale 1ns/1ps
module fspc_dev #(
  parameter int PROG_CYC = fspc_pkg::PROG_CYC
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // cpu side
  fspc_if.dev bus,
  // status
  output logic O_PROG_EN,
  output logic O_BUSY
);
  typedef enum logic [2:0] {S_IDLE, S_UNL, S_ERA, S_WRT, S_RD} fspc_dst_t;
  typedef struct packed {
    fspc_dst_t st;
    logic start;
    logic [2:0] mode;
    logic en;
    logic go;
    logic permit;
    logic rgo;
    logic [7:0] addr_low_reg;
    logic [3:0] addr_high_reg;
    logic [7:0][7:0] fd;
    logic [8:0] ptr;
    logic [7:0] rdata;
  } fspc_dev_t;

  fspc_dev_t r_r;
  fspc_dev_t r_nxt;
  logic [fspc_pkg::DW-1:0] mem [0:(1<<fspc_pkg::AW)-1];
  logic mem_we;
  logic [fspc_pkg::AW-1:0] mem_a;
  logic [fspc_pkg::AW-1:0] rd_a;
  logic [fspc_pkg::DW-1:0] mem_q;
  logic [2:0] fdi;
  logic in_fd;
  logic t_ld;
  logic [15:0] t_cnt;
  logic t_done;

  // ----
  // timer
  // ----
  fspc_timer fspc_timer_i (
    .i_clk(I_CLK_SYS),
    .i_nrst(I_NRST),
    .i_load(t_ld),
    .i_cnt(t_cnt),
    .o_done(t_done)
  );

  assign fdi = 3'(bus.addr - fspc_pkg::A_WORD0_LOW);
  assign in_fd = (bus.addr >= fspc_pkg::A_WORD0_LOW) && (bus.addr <= fspc_pkg::A_WORD3_HIGH);
  assign rd_a = {r_r.addr_high_reg, r_r.addr_low_reg};
  assign mem_q = mem[rd_a];
  assign bus.rdata = r_r.rdata;
  assign bus.stall = (r_r.st == S_ERA) || (r_r.st == S_WRT) || (r_r.st == S_RD);
  assign O_BUSY = bus.stall;
  assign O_PROG_EN = r_r.en;

  // ----
  // register access and sequencing
  // ----
  always_comb begin
    r_nxt = r_r;
    r_nxt.rdata = 8'h00;
    t_ld = 1'b0;
    t_cnt = 16'h0000;
    mem_we = 1'b0;
    mem_a = rd_a;
    if (bus.rd) begin
      if (bus.addr == fspc_pkg::A_FC0) begin
        r_nxt.rdata = {r_r.start, r_r.mode, r_r.en, r_r.go, r_r.permit, r_r.rgo};
      end else if (bus.addr == fspc_pkg::A_ADDR_LOW_REG) begin
        r_nxt.rdata = r_r.addr_low_reg;
      end else if (bus.addr == fspc_pkg::A_ADDR_HIGH_REG) begin
        r_nxt.rdata = {4'h0, r_r.addr_high_reg};
      end else if (in_fd) begin
        r_nxt.rdata = r_r.fd[fdi];
      end
    end
    if (bus.wr) begin
      if (bus.addr == fspc_pkg::A_FC0) begin
        r_nxt.mode = bus.wdata[fspc_pkg::B_MODE +: 3];
        r_nxt.permit = bus.wdata[fspc_pkg::B_PERM];
        r_nxt.en = r_r.en & bus.wdata[fspc_pkg::B_EN];
        if (r_r.st == S_IDLE && bus.wdata[fspc_pkg::B_START] && r_nxt.mode == fspc_pkg::M_UNLOCK) begin
          r_nxt.start = 1'b1;
          r_nxt.st = S_UNL;
          t_ld = 1'b1;
          t_cnt = 16'(fspc_pkg::UNL_CYC);
        end else if (r_r.st == S_IDLE && bus.wdata[fspc_pkg::B_GO] && r_r.en
                     && !bus.wdata[fspc_pkg::B_RGO]
                     && (r_nxt.mode == fspc_pkg::M_ERASE || r_nxt.mode == fspc_pkg::M_WRITE)) begin
          r_nxt.go = 1'b1;
          r_nxt.ptr = 9'h000;
          r_nxt.st = (r_nxt.mode == fspc_pkg::M_ERASE) ? S_ERA : S_WRT;
          t_ld = 1'b1;
          t_cnt = 16'(PROG_CYC);
        end else if (r_r.st == S_IDLE && bus.wdata[fspc_pkg::B_RGO] && r_r.permit
                     && r_nxt.permit && !bus.wdata[fspc_pkg::B_GO]
                     && r_nxt.mode == fspc_pkg::M_READ) begin
          r_nxt.rgo = 1'b1;
          r_nxt.st = S_RD;
          t_ld = 1'b1;
          t_cnt = 16'(fspc_pkg::RD_CYC);
        end
      end else if (bus.addr == fspc_pkg::A_ADDR_LOW_REG) begin
        r_nxt.addr_low_reg = bus.wdata;
      end else if (bus.addr == fspc_pkg::A_ADDR_HIGH_REG) begin
        r_nxt.addr_high_reg = bus.wdata[3:0];
      end else if (in_fd) begin
        r_nxt.fd[fdi] = bus.wdata;
      end
    end
    unique case (r_r.st)
      S_IDLE: begin
      end
      S_UNL: begin
        if (t_done) begin
          r_nxt.start = 1'b0;
          r_nxt.st = S_IDLE;
          if (r_r.mode == fspc_pkg::M_UNLOCK && r_r.fd[7:2] == fspc_pkg::KEY) begin
            r_nxt.en = 1'b1;
          end
        end
      end
      S_ERA: begin
        mem_a = {r_r.addr_high_reg, r_r.ptr[7:0]};
        if (r_r.ptr < fspc_pkg::BLK_WORDS) begin
          mem_we = 1'b1;
          r_nxt.ptr = r_r.ptr + 9'h001;
        end
        if (t_done) begin
          r_nxt.go = 1'b0;
          r_nxt.st = S_IDLE;
        end
      end
      S_WRT: begin
        mem_a = {r_r.addr_high_reg, r_r.addr_low_reg[7:2], r_r.ptr[1:0]};
        if (r_r.ptr < fspc_pkg::UNIT_WORDS) begin
          mem_we = 1'b1;
          r_nxt.ptr = r_r.ptr + 9'h001;
        end
        if (t_done) begin
          r_nxt.go = 1'b0;
          r_nxt.st = S_IDLE;
        end
      end
      S_RD: begin
        if (t_done) begin
          r_nxt.fd[0] = mem_q[7:0];
          r_nxt.fd[1] = mem_q[15:8];
          r_nxt.rgo = 1'b0;
          r_nxt.st = S_IDLE;
        end
      end
      default: begin
        r_nxt.st = S_IDLE;
      end
    endcase
  end

  // ----
  // state and array
  // ----
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (mem_we) begin
      if (r_r.st == S_ERA) begin
        mem[mem_a] <= 16'h0000;
      end else begin
        mem[mem_a] <= {r_r.fd[{r_r.ptr[1:0], 1'b1}], r_r.fd[{r_r.ptr[1:0], 1'b0}]};
      end
    end
  end
endmodule

//--- dv/fspc_properties.sv
`timescale 1ns/1ps
module fspc_properties #(
  parameter int PROG_CYC = fspc_pkg::PROG_CYC
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // interface signals
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic stall,
  // device status
  input wire logic i_prog_en
);
  typedef struct packed {
    logic op;
    logic [15:0] cnt;
    logic [7:0] lastfc;
  } fspc_chk_t;
  fspc_chk_t st_r;
  fspc_chk_t st_nxt;
  logic fc_wr;
  logic pgo;
  assign fc_wr = wr && (addr == fspc_pkg::A_FC0);
  assign pgo = fc_wr && (wdata == fspc_pkg::FC_ERGO || wdata == fspc_pkg::FC_WRGO);
  // ----
  // helper: stall length and last control word
  // ----
  always_comb begin
    st_nxt = st_r;
    st_nxt.cnt = stall ? st_r.cnt + 16'h0001 : 16'h0000;
    if (fc_wr) begin
      st_nxt.lastfc = wdata;
      if (pgo) begin
        st_nxt.op = 1'b1;
      end
      if (wdata == fspc_pkg::FC_RDGO) begin
        st_nxt.op = 1'b0;
      end
    end
  end
  always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
    if (!I_NRST) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_NRST);
  prog_launch_a: assert property (pgo && i_prog_en && !stall |=> stall)
    else $error("erase or write launch did not stall");
  locked_go_a: assert property (fc_wr && wdata[2] && !i_prog_en |=> !stall [*3])
    else $error("go accepted while locked");
  read_launch_a: assert property (fc_wr && wdata == fspc_pkg::FC_RDGO && st_r.lastfc == fspc_pkg::FC_RD
    && !stall |=> stall)
    else $error("read launch did not stall");
  prog_time_a: assert property ($fell(stall) && st_r.op |-> int'(st_r.cnt) >= PROG_CYC - 2 && int'(st_r.cnt) <= PROG_CYC)
    else $error("program stall length wrong");
  prog_bound_a: assert property (stall |-> int'(st_r.cnt) <= PROG_CYC)
    else $error("stall never ended");
  read_time_a: assert property ($fell(stall) && !st_r.op |-> int'(st_r.cnt) >= fspc_pkg::RD_CYC - 2
    && int'(st_r.cnt) <= fspc_pkg::RD_CYC)
    else $error("read stall length wrong");
  stall_cause_a: assert property ($rose(stall) |-> $past(fc_wr) && ($past(wdata[2]) || $past(wdata[0])))
    else $error("stall without launch");
  relock_clear_a: assert property (fc_wr && !wdata[3] && !stall |=> !i_prog_en)
    else $error("flag clear did not relock");
  unlock_order_a: assert property (fc_wr && wdata[7] |-> st_r.lastfc == fspc_pkg::FC_UNL)
    else $error("window armed without unlock mode");
  mode_first_a: assert property (fc_wr && (wdata[2] || wdata[0]) |-> st_r.lastfc == (wdata & 8'hfa))
    else $error("go without mode set first");
  go_combo_a: assert property (fc_wr |-> !(wdata[2] && wdata[1] && wdata[0]))
    else $error("go permit and read go set together");
  go_clear_a: assert property (rd && addr == fspc_pkg::A_FC0 && !stall
    |=> !rdata[fspc_pkg::B_GO] && !rdata[fspc_pkg::B_RGO])
    else $error("go bit seen high while idle");
endmodule

//--- dv/fspc_tb.sv
`timescale 1ns/1ps
module fspc_tb;
  localparam int PCYC = 300;
  logic clk;
  logic nrst;
  logic [3:0] h_addr;
  logic [7:0] h_wdata;
  logic h_wr;
  logic h_rd;
  logic [7:0] h_rdata;
  logic h_busy;
  logic prog_en;
  logic d_busy;
  logic prog_en2;
  logic busy2;
  int err_total = 0;
  int checked = 0;
  fspc_if bus();
  fspc_if bus2();
  fspc_host fspc_host_i (.I_CLK_SYS(clk), .I_NRST(nrst), .I_ADDR(h_addr), .I_WDATA(h_wdata), .I_WR(h_wr),
    .I_RD(h_rd), .O_RDATA(h_rdata), .O_BUSY(h_busy), .bus(bus.cpu));
  fspc_dev #(.PROG_CYC(PCYC)) fspc_dev_i (.I_CLK_SYS(clk), .I_NRST(nrst), .bus(bus.dev),
    .O_PROG_EN(prog_en), .O_BUSY(d_busy));
  fspc_dev #(.PROG_CYC(PCYC)) fspc_dev_x_i (.I_CLK_SYS(clk), .I_NRST(nrst), .bus(bus2.dev),
    .O_PROG_EN(prog_en2), .O_BUSY(busy2));
  fspc_properties #(.PROG_CYC(PCYC)) fspc_properties_i (.I_CLK_SYS(clk), .I_NRST(nrst), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .stall(bus.stall), .i_prog_en(prog_en));
  // ----
  // compare and bus tasks
  // ----
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hwr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    h_addr <= a;
    h_wdata <= d;
    h_wr <= 1'b1;
    @(posedge clk);
    h_wr <= 1'b0;
  endtask
  task automatic hrd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    h_addr <= a;
    h_rd <= 1'b1;
    @(posedge clk);
    h_rd <= 1'b0;
    #1 d = h_rdata;
  endtask
  task automatic cmd(input logic [2:0] c);
    int n;
    n = 0;
    hwr(4'h0, {5'h00, c});
    repeat (2) @(posedge clk);
    #1;
    while (h_busy !== 1'b0 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(h_busy, 1'b0);
  endtask
  task automatic setaddr(input logic [11:0] a);
    hwr(4'h1, a[7:0]);
    hwr(4'h2, {4'h0, a[11:8]});
  endtask
  task automatic rdword(input logic [11:0] a, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    setaddr(a);
    cmd(fspc_pkg::C_READ);
    hrd(4'h8, lo);
    hrd(4'h9, hi);
    chk_word({hi, lo}, exp);
  endtask
  task automatic d2wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus2.addr <= a;
    bus2.wdata <= d;
    bus2.wr <= 1'b1;
    @(posedge clk);
    bus2.wr <= 1'b0;
  endtask
  task automatic d2rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus2.addr <= a;
    bus2.rd <= 1'b1;
    @(posedge clk);
    bus2.rd <= 1'b0;
    #1 d = bus2.rdata;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_badkey();
    logic [7:0] d;
    d2wr(fspc_pkg::A_FC0, fspc_pkg::FC_ER);
    d2wr(fspc_pkg::A_FC0, fspc_pkg::FC_ERGO);
    #1 chk_bit(busy2, 1'b0);
    d2rd(fspc_pkg::A_FC0, d);
    chk_bit(d[fspc_pkg::B_GO], 1'b0);
    d2wr(fspc_pkg::A_FC0, fspc_pkg::FC_UNL);
    d2wr(fspc_pkg::A_FC0, fspc_pkg::FC_UNLGO);
    for (int i = 0; i < 6; i++) begin
      d2wr(fspc_pkg::A_WORD0_LOW + 8'h02 + 8'(i), fspc_pkg::KEY[8*i+:8] ^ ((i == 5) ? 8'h01 : 8'h00));
    end
    d2rd(fspc_pkg::A_FC0, d);
    chk_bit(d[fspc_pkg::B_START], 1'b1);
    repeat (fspc_pkg::UNL_CYC) @(posedge clk);
    d2rd(fspc_pkg::A_FC0, d);
    chk_bit(d[fspc_pkg::B_START], 1'b0);
    chk_bit(d[fspc_pkg::B_EN], 1'b0);
    chk_bit(prog_en2, 1'b0);
    $display("test badkey done");
  endtask
  task automatic t_unlock_erase();
    chk_bit(prog_en, 1'b0);
    cmd(fspc_pkg::C_UNLOCK);
    chk_bit(prog_en, 1'b1);
    setaddr(12'h340);
    // launch without waiting, then see the device stall; the repeated command is ignored while busy
    hwr(4'h0, {5'h00, fspc_pkg::C_ERASE});
    repeat (20) @(posedge clk);
    #1 chk_bit(d_busy, 1'b1);
    cmd(fspc_pkg::C_ERASE);
    chk_bit(d_busy, 1'b0);
    rdword(12'h300, 16'h0000);
    rdword(12'h3ff, 16'h0000);
    rdword(12'h340, 16'h0000);
    $display("test unlock_erase done");
  endtask
  task automatic t_write();
    setaddr(12'h313);
    for (int i = 0; i < 4; i++) begin
      hwr(4'(8 + 2 * i), 8'h50 + 8'(i));
      hwr(4'(9 + 2 * i), 8'ha0 + 8'(i));
    end
    cmd(fspc_pkg::C_WRITE);
    for (int i = 0; i < 4; i++) begin
      rdword(12'h310 + 12'(i), {8'ha0 + 8'(i), 8'h50 + 8'(i)});
    end
    rdword(12'h314, 16'h0000);
    $display("test write done");
  endtask
  task automatic t_relock();
    cmd(fspc_pkg::C_LOCK);
    chk_bit(prog_en, 1'b0);
    setaddr(12'h310);
    hwr(4'h8, 8'hff);
    cmd(fspc_pkg::C_WRITE);
    rdword(12'h310, 16'ha050);
    setaddr(12'h300);
    cmd(fspc_pkg::C_ERASE);
    rdword(12'h311, 16'ha151);
    $display("test relock done");
  endtask
  // ----
  // clock, watchdog and main sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 40000);
    err_total++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    h_addr = 4'h0;
    h_wdata = 8'h00;
    h_wr = 1'b0;
    h_rd = 1'b0;
    bus2.addr = 8'h00;
    bus2.wdata = 8'h00;
    bus2.wr = 1'b0;
    bus2.rd = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_badkey();
    t_unlock_erase();
    t_write();
    t_relock();
    give_verdict();
  end
endmodule
